// ### hdl/gtimer_consts.svh
/*
 Register offsets, field positions, reset values and timing constants of the gated 16-bit timer.
 Assumes inclusion by bare name from files under hdl/.
*/
`ifndef GTIMER_CONSTS_SVH
`define GTIMER_CONSTS_SVH

`define ADDR_CLK_CTRL 4'h0
`define ADDR_GATE_CTRL 4'h1
`define ADDR_COUNT_HIGH 4'h2
`define ADDR_COUNT_LOW 4'h3
`define ADDR_IRQ_STATUS 4'h4
`define ADDR_IRQ_MASK 4'h5

`define CLK_CTRL_RESET 8'h00
`define GATE_CTRL_RESET 8'h00
`define CLK_CTRL_WMASK 8'hfd
`define GATE_CTRL_WMASK 8'hfb

// timer clock control fields
`define F_CS_HI 7
`define F_CS_LO 6
`define F_PS_HI 5
`define F_PS_LO 4
`define F_OSCEN 3
`define F_SYNCB 2
`define F_RUN 0
// gate control fields
`define F_GE 7
`define F_GPOL 6
`define F_GTM 5
`define F_GSPM 4
`define F_ARM 3
`define F_GVAL 2
`define F_GSS_HI 1
`define F_GSS_LO 0
// status / mask bits
`define IRQ_OVF 0
`define IRQ_GATE 1

`define SYSDIV_COUNT 2'h3
`endif

// ### hdl/gtimer_pkg.sv
/*
 Types of the gated 16-bit timer.
 Assumes nothing of its surroundings.
*/
package gtimer_pkg;
  typedef enum logic [1:0] {
    CS_SYS_DIV4,
    CS_SYS,
    CS_PIN_OSC,
    CS_CAP_OSC
  } clk_src_t;
  typedef enum logic [1:0] {
    GS_PIN,
    GS_T0_OVF,
    GS_CMP1,
    GS_CMP2
  } gate_src_t;
  typedef enum logic [1:0] {
    SP_IDLE,
    SP_WAIT,
    SP_OPEN
  } pulse_state_t;
endpackage

// ### hdl/gtimer_gate.sv
/*
 Gate conditioning path: source select, polarity, toggle flop, single-pulse stage.
 Assumes all inputs synchronous to clk_i.
*/
`include "gtimer_consts.svh"
module gtimer_gate
  import gtimer_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic [1:0] src_sel_i, // gate source select
  input wire logic pin_i, // gate pin
  input wire logic t0_ovf_i, // 8-bit timer overflow pulse
  input wire logic cmp1_output_i, // comparator 1
  input wire logic cmp2_output_i, // comparator 2
  input wire logic polarity_i, // active level
  input wire logic toggle_mode_i, // toggle mode
  input wire logic run_i, // timer run
  input wire logic single_pulse_i, // single pulse mode
  input wire logic arm_set_i, // software sets arm bit
  input wire logic arm_clr_i, // software clears arm bit
  output logic arm_o, // arm status
  output logic gate_o // conditioned gate level
);
  logic src;
  logic pol_gate;
  logic pol_prev;
  logic tog;
  logic tog_gate;
  logic tog_prev;
  logic sp_gate;
  pulse_state_t state;

  assign src = (src_sel_i == 2'h3) ? cmp2_output_i :
               (src_sel_i == 2'h2) ? cmp1_output_i :
               (src_sel_i == 2'h1) ? t0_ovf_i : pin_i;
  assign pol_gate = polarity_i ? src : ~src;
  assign tog_gate = toggle_mode_i ? tog : pol_gate;
  assign sp_gate = (state == SP_OPEN);
  assign gate_o = single_pulse_i ? sp_gate : tog_gate;
  assign arm_o = (state != SP_IDLE);

  always_ff @(posedge clk_i) begin
    pol_prev <= rst_i ? 1'b0 : pol_gate;
    tog_prev <= rst_i ? 1'b0 : tog_gate;
  end

  // toggle flop held clear when mode off or timer stopped
  always_ff @(posedge clk_i) begin
    if (rst_i || !toggle_mode_i || !run_i) begin
      tog <= 1'b0;
    end else if (pol_gate && !pol_prev) begin
      tog <= ~tog;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !single_pulse_i || arm_clr_i) begin
      state <= SP_IDLE;
    end else begin
      unique case (state)
        SP_IDLE: begin
          if (arm_set_i) begin
            state <= SP_WAIT;
          end
        end
        SP_WAIT: begin
          if (tog_gate && !tog_prev) begin
            state <= SP_OPEN;
          end
        end
        SP_OPEN: begin
          if (!tog_gate) begin
            state <= SP_IDLE;
          end
        end
        default: state <= SP_IDLE;
      endcase
    end
  end
endmodule

// ### hdl/gtimer_top.sv
/*
 Gated 16-bit timer/counter with AXI4-Lite register slave and level interrupt.
 Assumes all inputs synchronous to clk_i; external clocks are sampled, so they must
 run below half the system clock.
*/
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`include "gtimer_consts.svh"
module gtimer_top
  import gtimer_pkg::*;
(
  input wire logic clk_i, // system clock 10 MHz
  input wire logic rst_i, // power-on reset, sync, high
  input wire logic [5:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [5:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic ext_clock_pin_i, // external count clock
  input wire logic xtal_osc_i, // crystal oscillator clock
  input wire logic cap_sense_osc_i, // capacitive sensing oscillator
  input wire logic gate_pin_i, // gate pin
  input wire logic t0_ovf_i, // 8-bit timer overflow pulse
  input wire logic cmp1_output_i, // comparator 1 output
  input wire logic cmp2_output_i, // comparator 2 output
  output logic osc_enable_o, // dedicated oscillator power
  output logic irq_o // interrupt, high level
);
  logic [7:0] clk_ctrl;
  logic [7:0] gate_ctrl;
  logic [15:0] count;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] sysdiv;
  logic [2:0] presc;
  logic ext_s1, ext_s2, ext_prev;
  logic gate_prev;
  logic aw_held, w_held;
  logic [3:0] aw_idx;
  logic [31:0] wdata;
  logic [3:0] wstrb;

  // write channel: address and data taken in either order, once per transfer
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire wr_lane0 = wr_fire && wstrb[0];
  wire wr_clk = wr_lane0 && (aw_idx == `ADDR_CLK_CTRL);
  wire wr_gate = wr_lane0 && (aw_idx == `ADDR_GATE_CTRL);
  wire wr_hi = wr_lane0 && (aw_idx == `ADDR_COUNT_HIGH);
  wire wr_lo = wr_lane0 && (aw_idx == `ADDR_COUNT_LOW);
  wire wr_st = wr_lane0 && (aw_idx == `ADDR_IRQ_STATUS);
  wire wr_mk = wr_lane0 && (aw_idx == `ADDR_IRQ_MASK);
  wire wr_bad = aw_idx > `ADDR_IRQ_MASK;

  wire run = clk_ctrl[`F_RUN];
  wire gate_en = gate_ctrl[`F_GE];
  wire [1:0] cs = clk_ctrl[`F_CS_HI:`F_CS_LO];
  wire [1:0] ps = clk_ctrl[`F_PS_HI:`F_PS_LO];

  // async source: raw when sync bypassed, else two-flop synchronised
  wire ext_src = clk_ctrl[`F_OSCEN] ? xtal_osc_i : ext_clock_pin_i;
  wire ext_level = clk_ctrl[`F_SYNCB] ? ext_src : ext_s2;
  wire ext_rise = ext_level && !ext_prev;
  logic cap_s1, cap_s2, cap_prev;
  wire cap_edge = cap_s2 && !cap_prev;
  wire src_tick = (cs == 2'h3) ? cap_edge :
                  (cs == 2'h2) ? ext_rise :
                  (cs == 2'h1) ? 1'b1 :
                  (sysdiv == `SYSDIV_COUNT);
  wire [2:0] ps_max = (ps == 2'h3) ? 3'h7 : (ps == 2'h2) ? 3'h3 :
                      (ps == 2'h1) ? 3'h1 : 3'h0;
  wire pre_tick = src_tick && (presc >= ps_max);

  logic gate_level;
  logic arm;
  wire count_ok = run && (!gate_en || gate_level);
  wire inc = pre_tick && count_ok;
  wire rollover = inc && (count == 16'hffff);
  wire gate_fall = gate_prev && !gate_level;
  wire [1:0] events = {gate_fall, rollover};

  wire [7:0] gate_rd = {gate_ctrl[7:4], arm, gate_level, gate_ctrl[1:0]};
  wire [3:0] ar_idx = s_axi_araddr[5:2];
  wire [7:0] rd_byte = (ar_idx == `ADDR_CLK_CTRL) ? clk_ctrl :
                       (ar_idx == `ADDR_GATE_CTRL) ? gate_rd :
                       (ar_idx == `ADDR_COUNT_HIGH) ? count[15:8] :
                       (ar_idx == `ADDR_COUNT_LOW) ? count[7:0] :
                       (ar_idx == `ADDR_IRQ_STATUS) ? {6'h00, irq_status} :
                       (ar_idx == `ADDR_IRQ_MASK) ? {6'h00, irq_mask} : 8'h00;
  wire rd_bad = ar_idx > `ADDR_IRQ_MASK;
  wire [7:0] next_clk_ctrl = (wdata[7:0] & `CLK_CTRL_WMASK);
  wire [7:0] next_gate_ctrl = (wdata[7:0] & `GATE_CTRL_WMASK);

  gtimer_gate gate_path (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_sel_i(gate_ctrl[`F_GSS_HI:`F_GSS_LO]),
    .pin_i(gate_pin_i),
    .t0_ovf_i(t0_ovf_i),
    .cmp1_output_i(cmp1_output_i),
    .cmp2_output_i(cmp2_output_i),
    .polarity_i(gate_ctrl[`F_GPOL]),
    .toggle_mode_i(gate_ctrl[`F_GTM]),
    .run_i(run),
    .single_pulse_i(gate_ctrl[`F_GSPM]),
    .arm_set_i(wr_gate && wdata[`F_ARM]),
    .arm_clr_i(wr_gate && !wdata[`F_ARM]),
    .arm_o(arm),
    .gate_o(gate_level)
  );

  always_ff @(posedge clk_i) begin
    ext_s1 <= rst_i ? 1'b0 : ext_src;
    ext_s2 <= rst_i ? 1'b0 : ext_s1;
    ext_prev <= rst_i ? 1'b0 : ext_level;
    cap_s1 <= rst_i ? 1'b0 : cap_sense_osc_i;
    cap_s2 <= rst_i ? 1'b0 : cap_s1;
    cap_prev <= rst_i ? 1'b0 : cap_s2;
    gate_prev <= rst_i ? 1'b0 : gate_level;
  end

  always_ff @(posedge clk_i) begin
    sysdiv <= rst_i ? 2'h0 : sysdiv + 2'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !run) begin
      presc <= 3'h0;
    end else if (src_tick) begin
      presc <= pre_tick ? 3'h0 : presc + 3'h1;
    end
  end

  // writes win over an increment in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= 16'h0000;
    end else if (wr_hi) begin
      count[15:8] <= wdata[7:0];
    end else if (wr_lo) begin
      count[7:0] <= wdata[7:0];
    end else if (inc) begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_ctrl <= `CLK_CTRL_RESET;
      gate_ctrl <= `GATE_CTRL_RESET;
      irq_mask <= 2'h0;
    end else begin
      if (wr_clk) clk_ctrl <= next_clk_ctrl;
      if (wr_gate) gate_ctrl <= next_gate_ctrl;
      if (wr_mk) irq_mask <= wdata[1:0];
    end
  end

  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= (irq_status & ~(wr_st ? wdata[1:0] : 2'h0)) | events;
    end
  end

  always_ff @(posedge clk_i) begin
    osc_enable_o <= rst_i ? 1'b0 : clk_ctrl[`F_OSCEN];
    irq_o <= rst_i ? 1'b0 : |(irq_status & irq_mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 4'h0;
      wdata <= 32'h0;
      wstrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_held && !w_take && !s_axi_bvalid;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[5:2];
      end
      if (w_take) begin
        w_held <= 1'b1;
        wdata <= s_axi_wdata;
        wstrb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_bad ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_bad ? 2'h2 : 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ### testbench/gtimer_chk.sv
/*
 Checker for gtimer_top: register bus answers, reset state and oscillator power.
 Assumes one clock domain and is attached by the bind at the foot of this file.
*/
module gtimer_chk (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic [5:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // strobes
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic [5:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // r valid
  input wire logic osc_enable_o, // osc power
  input wire logic irq_o // interrupt
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_osc;
    logic v;
    (s_wr ##0 (s_axi_awaddr == 6'h00 && s_axi_wstrb[0]), v = s_axi_wdata[3])
      |-> ##3 osc_enable_o == v;
  endproperty
  AST_OSC_FOLLOWS: assert property (p_osc)
    else $error("osc power does not follow control write");
  AST_RESET_CLEARS: assert property (disable iff (1'b0) rst_i |=> !irq_o && !osc_enable_o)
    else $error("outputs not cleared by reset");
  AST_WR_ANSWER: assert property (s_wr |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_RD_ANSWER: assert property (s_rd |=> s_axi_rvalid)
    else $error("read data late");
  AST_RD_UNMAPPED: assert property (s_rd ##0 s_axi_araddr[5:2] > 4'h5 |=>
    s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  AST_RD_MAPPED: assert property (s_rd ##0 s_axi_araddr[5:2] <= 4'h5 |=>
    s_axi_rresp == 2'b00 && s_axi_rdata[31:8] == 24'h0) else $error("mapped read wrong");
  AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule
bind gtimer_top gtimer_chk u_gtimer_chk (.clk_i(clk_i), .rst_i(rst_i),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .osc_enable_o(osc_enable_o),
  .irq_o(irq_o));

// ### testbench/gated_16bit_timer_control_bench.sv
/*
 Self-checking bench for gtimer_top: registers, count rates, gate path, interrupts.
 Assumes the checker is bound elsewhere; every input driven from clk_i edges.
*/
module gated_16bit_timer_control_bench import gtimer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awr, wrdy, bv, arr, rv, osc_en, irq;
  logic [1:0] bresp, rresp, rresp_l, bresp_l;
  logic gpin = 0, t0 = 0, c1 = 0, c2 = 0, ext = 0, xt = 0, cap = 0;
  logic [7:0] dl;
  int err_count = 0, cmp_count = 0, cyc = 0, tread = 0, el;
  gtimer_top u_gtimer_top (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .ext_clock_pin_i(ext), .xtal_osc_i(xt), .cap_sense_osc_i(cap), .gate_pin_i(gpin),
    .t0_ovf_i(t0), .cmp1_output_i(c1), .cmp2_output_i(c2), .osc_enable_o(osc_en),
    .irq_o(irq));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // free-running count clocks of periods 8, 4 and 16 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    ext <= cyc[2];
    xt <= cyc[1];
    cap <= cyc[3];
    if (cyc == 30000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // count phase against the prescaler is unknown, so one tick either way
  task automatic near(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (!(g === e || g === e + 8'h1 || g === e - 8'h1)) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(posedge clk_i);
      if (awv && awr) awv <= 0;
      if (wv && wrdy) wv <= 0;
    end while (bv !== 1'b1);
    bresp_l = bresp;
    bready <= 0;
  endtask
  task automatic rd8(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_i);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do begin
      @(posedge clk_i);
      if (arv && arr) arv <= 0;
    end while (rv !== 1'b1);
    d = rdata;
    rresp_l = rresp;
    tread = cyc;
    rready <= 0;
  endtask
  task automatic span(output logic [7:0] d, output int e);
    logic [31:0] a, b;
    int t;
    rd8(6'h0c, a);
    t = tread;
    repeat (128) @(posedge clk_i);
    rd8(6'h0c, b);
    d = b[7:0] - a[7:0];
    e = tread - t;
  endtask
  task automatic pulse;
    gpin <= 1;
    repeat (12) @(posedge clk_i);
    gpin <= 0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic t_regs;
    rd8(6'h00, rd);
    check("clock ctrl reset", 32'h0, rd);
    rd8(6'h04, rd);
    check("gate ctrl reset", 32'h0, rd & 32'hfb);
    rd8(6'h18, rd);
    check("unmapped resp", 32'h2, {30'h0, rresp_l});
    wr(6'h18, 8'h00);
    check("unmapped write resp", 32'h2, {30'h0, bresp_l});
    wr(6'h00, 8'hfe);
    rd8(6'h00, rd);
    check("clock ctrl", 32'hfc, rd);
    check("osc power", 32'h1, {31'h0, osc_en});
    wr(6'h04, 8'he3);
    rd8(6'h04, rd);
    check("gate ctrl", 32'he3, rd & 32'hfb);
    wr(6'h08, 8'ha5);
    wr(6'h0c, 8'h5a);
    rd8(6'h08, rd);
    check("count high", 32'ha5, rd);
    rd8(6'h0c, rd);
    check("count low", 32'h5a, rd);
    wr(6'h04, 8'h00);
    $display("register test done");
  endtask
  task automatic t_rates;
    logic [7:0] cfg [10] = '{8'h41, 8'h51, 8'h61, 8'h71, 8'h01, 8'h31, 8'h81, 8'h89, 8'h85,
                             8'hc1};
    int dv [10] = '{1, 2, 4, 8, 4, 32, 8, 4, 8, 16};
    for (int i = 0; i < 10; i++) begin
      wr(6'h00, cfg[i]);
      span(dl, el);
      near("count rate", 8'(el / dv[i]), dl);
    end
    $display("rate test done");
  endtask
  task automatic t_gate;
    wr(6'h00, 8'h41);
    wr(6'h04, 8'hc0);
    span(dl, el);
    near("gate closed", 8'h0, dl);
    gpin <= 1;
    span(dl, el);
    near("gate open", 8'(el), dl);
    wr(6'h04, 8'h80);
    span(dl, el);
    near("low polarity", 8'h0, dl);
    wr(6'h04, 8'h00);
    span(dl, el);
    near("gate ignored", 8'(el), dl);
    wr(6'h00, 8'h40);
    span(dl, el);
    near("stopped", 8'h0, dl);
    for (int s = 0; s < 4; s++) begin
      wr(6'h04, 8'h40 | 8'(s));
      {c2, c1, t0, gpin} <= 4'h1 << s;
      repeat (4) @(posedge clk_i);
      rd8(6'h04, rd);
      check("gate level high", 32'h4, rd & 32'h4);
      {c2, c1, t0, gpin} <= ~(4'h1 << s);
      repeat (4) @(posedge clk_i);
      rd8(6'h04, rd);
      check("gate level low", 32'h0, rd & 32'h4);
    end
    {c2, c1, t0, gpin} <= 4'h0;
    rd8(6'h10, rd);
    check("gate event", 32'h2, rd);
    wr(6'h14, 8'h02);
    repeat (3) @(posedge clk_i);
    check("irq raised", 32'h1, {31'h0, irq});
    wr(6'h10, 8'h02);
    repeat (3) @(posedge clk_i);
    check("irq cleared", 32'h0, {31'h0, irq});
    $display("gate test done");
  endtask
  task automatic t_ovf;
    wr(6'h14, 8'h00);
    wr(6'h08, 8'hff);
    wr(6'h0c, 8'hf0);
    wr(6'h00, 8'h41);
    repeat (30) @(posedge clk_i);
    rd8(6'h10, rd);
    check("overflow flag", 32'h1, rd);
    check("masked irq", 32'h0, {31'h0, irq});
    wr(6'h10, 8'h01);
    rd8(6'h10, rd);
    check("overflow cleared", 32'h0, rd);
    $display("overflow test done");
  endtask
  task automatic t_modes;
    logic [31:0] a, b;
    wr(6'h04, 8'h60);
    pulse();
    rd8(6'h04, rd);
    check("toggle set", 32'h4, rd & 32'h4);
    wr(6'h00, 8'h40);
    rd8(6'h04, rd);
    check("toggle run clear", 32'h0, rd & 32'h4);
    wr(6'h00, 8'h41);
    wr(6'h04, 8'hd0);
    wr(6'h04, 8'hd8);
    rd8(6'h04, rd);
    check("armed", 32'h8, rd & 32'h8);
    rd8(6'h0c, a);
    pulse();
    rd8(6'h0c, b);
    near("single window", 8'd12, b[7:0] - a[7:0]);
    rd8(6'h04, rd);
    check("disarmed", 32'h0, rd & 32'h8);
    pulse();
    rd8(6'h0c, a);
    check("no second pulse", b, a);
    $display("mode test done");
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_rates();
    t_gate();
    t_ovf();
    t_modes();
    conclude();
  end
endmodule
